/* File: bench/slice_asserts.sv */
// Port checks for the bit-test, branch and call slice.
// Assumes a bind into the slice top: one clock, async low reset.
`timescale 1ns/1ns
module slice_asserts (
    input wire logic        clk_sys,
    input wire logic        arst_n,
    input wire logic [20:0] prog_addr,
    input wire logic        cycle_end,
    input wire logic        empty_cycle
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    AST_EMPTY_AT_END: assert property (
        empty_cycle |-> cycle_end)
        else $error("empty flag off a cycle end");
    AST_EMPTY_SPACING: assert property (
        empty_cycle |=> !empty_cycle [*3])
        else $error("empty flags too close");
    AST_END_SPACING: assert property (
        cycle_end |=> !cycle_end [*3])
        else $error("cycle ends too close");
    AST_PC_EVEN: assert property (
        prog_addr[0] == 1'b0)
        else $error("odd program address");
    // An empty cycle still fetches, so the address moves one word
    AST_EMPTY_STEP: assert property (
        cycle_end && empty_cycle
        |-> prog_addr == $past(prog_addr, 4) + 21'h2)
        else $error("empty cycle did not step the address");
    AST_JUMP_EMPTY: assert property (
        cycle_end && prog_addr != $past(prog_addr, 4) + 21'h2
        |-> ##4 cycle_end && empty_cycle)
        else $error("jump not followed by an empty cycle");
    AST_JUMP_ONE_EMPTY: assert property (
        cycle_end && prog_addr != $past(prog_addr, 4) + 21'h2
        |-> ##8 cycle_end && !empty_cycle)
        else $error("jump followed by two empty cycles");
    AST_TWO_EMPTY_MAX: assert property (
        cycle_end && empty_cycle && $past(empty_cycle, 4)
        |-> ##4 cycle_end && !empty_cycle)
        else $error("three empty cycles in a row");
endmodule : slice_asserts

/* File: bench/tb_top.sv */
// Self-checking bench for the bit-test, branch and call slice.
// Assumes program memory is a bench array answering one clock late.
`timescale 1ns/1ns
module tb_top;
    logic        clk_sys = 1'b0;
    logic        arst_n = 1'b0;
    logic [15:0] prog_data = 16'h0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [12:0] reg_addr = 13'h0000;
    logic [7:0]  reg_wdata = 8'h00;
    logic [20:0] prog_addr;
    logic [7:0]  reg_rdata;
    logic        cycle_end;
    logic        empty_cycle;
    logic [15:0] pmem [256];
    logic [21:0] exp_q [$];
    int          n_fail = 0;
    int          compares = 0;

    always #2 clk_sys = ~clk_sys;
    // One clock late is safe: prog_addr stands for four clocks
    always @(posedge clk_sys) prog_data <= pmem[prog_addr[8:1]];

    bit_test_branch_call_decode u_bit_test_branch_call_decode (
        .clk_sys     (clk_sys),
        .arst_n      (arst_n),
        .prog_data   (prog_data),
        .reg_wr      (reg_wr),
        .reg_rd      (reg_rd),
        .reg_addr    (reg_addr),
        .reg_wdata   (reg_wdata),
        .prog_addr   (prog_addr),
        .reg_rdata   (reg_rdata),
        .cycle_end   (cycle_end),
        .empty_cycle (empty_cycle)
    );

    task automatic print_verdict;
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : print_verdict

    task automatic chk_step(input logic [21:0] g, input logic [21:0] e);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk_step

    task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk_byte

    // A gap cycle before each strobe keeps one assignment per step
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rdchk(input logic [12:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk_byte(reg_rdata, e);
    endtask : rdchk

    // Trace entry: empty flag on top of the address after each cycle
    task automatic run_chk(input logic [20:0] s);
        int k;
        wr(13'h1007, s[7:0]);
        wr(13'h1008, s[15:8]);
        wr(13'h1009, {3'h0, s[20:16]});
        repeat (8) @(posedge clk_sys);
        wr(13'h1000, 8'h01);
        foreach (exp_q[i]) begin
            k = 0;
            do begin
                @(posedge clk_sys);
                #1 k++;
            end while (cycle_end !== 1'b1 && k < 16);
            chk_step({empty_cycle, prog_addr}, exp_q[i]);
        end
        wr(13'h1000, 8'h00);
    endtask : run_chk

    task automatic t_skip_set;
        pmem = '{default: 16'h0000};
        pmem[0] = 16'ha210;
        pmem[2] = 16'ha310;
        wr(13'h0010, 8'h02);
        wr(13'h0210, 8'h00);
        wr(13'h1003, 8'h02);
        exp_q = {22'h200002, 22'h4, 22'h200006, 22'h8, 22'ha};
        run_chk(21'h0);
    endtask : t_skip_set

    task automatic t_skip_clr;
        pmem = '{default: 16'h0000};
        pmem[0] = 16'hbe80;
        pmem[1] = 16'hec05;
        pmem[2] = 16'hf000;
        pmem[3] = 16'hb110;
        wr(13'h0f80, 8'h00);
        wr(13'h0210, 8'h01);
        exp_q = {22'h200002, 22'h4, 22'h200006, 22'h200008, 22'ha, 22'hc};
        run_chk(21'h0);
    endtask : t_skip_clr

    task automatic t_invert;
        pmem = '{default: 16'h0000};
        pmem[0] = 16'h7830;
        pmem[1] = 16'h7130;
        wr(13'h0030, 8'h75);
        wr(13'h0230, 8'h00);
        wr(13'h1002, 8'h0c);
        exp_q = {22'h200002, 22'h4, 22'h6, 22'h8};
        run_chk(21'h0);
        rdchk(13'h0030, 8'h65);
        rdchk(13'h0230, 8'h01);
        rdchk(13'h1002, 8'h0c);
    endtask : t_invert

    task automatic t_branch;
        pmem = '{default: 16'h0000};
        pmem[8'h20] = 16'he005;
        pmem[8'h21] = 16'he403;
        pmem[8'h23] = 16'he408;
        pmem[8'h25] = 16'he4fd;
        wr(13'h1002, 8'h08);
        exp_q = {22'h200042, 22'h44, 22'h4a, 22'h20004c, 22'h46,
                 22'h200048, 22'h58, 22'h20005a, 22'h5c, 22'h5e, 22'h60};
        run_chk(21'h40);
        pmem[8'h20] = 16'he405;
        pmem[8'h21] = 16'he07f;
        wr(13'h1002, 8'h04);
        exp_q = {22'h200042, 22'h44, 22'h142, 22'h200144, 22'h146, 22'h148};
        run_chk(21'h40);
        rdchk(13'h1002, 8'h04);
    endtask : t_branch

    task automatic t_call;
        pmem = '{default: 16'h0000};
        pmem[8'h40] = 16'hedde;
        pmem[8'h41] = 16'hfabc;
        pmem[8'h48] = 16'hec30;
        pmem[8'h49] = 16'hf000;
        wr(13'h1001, 8'h5a);
        wr(13'h1002, 8'h0c);
        wr(13'h1003, 8'h03);
        exp_q = {22'h200082, 22'h1579bc, 22'h3579be, 22'h1579c0};
        run_chk(21'h80);
        rdchk(13'h100a, 8'h84);
        rdchk(13'h100b, 8'h00);
        rdchk(13'h100c, 8'h00);
        rdchk(13'h100d, 8'h01);
        rdchk(13'h1002, 8'h0c);
        rdchk(13'h1009, 8'h15);
        wr(13'h1001, 8'h11);
        wr(13'h1002, 8'h00);
        wr(13'h1003, 8'h05);
        exp_q = {22'h200092, 22'h60, 22'h200062, 22'h64, 22'h66};
        run_chk(21'h90);
        rdchk(13'h100a, 8'h94);
        rdchk(13'h100d, 8'h02);
        rdchk(13'h1004, 8'h5a);
        rdchk(13'h1005, 8'h0c);
        rdchk(13'h1006, 8'h03);
    endtask : t_call

    // A reset while running must stop the core and clear its registers
    task automatic t_reset;
        wr(13'h1000, 8'h01);
        repeat (10) @(posedge clk_sys);
        arst_n <= 1'b0;
        repeat (5) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        #1 chk_step({empty_cycle, prog_addr}, 22'h0);
        rdchk(13'h1000, 8'h00);
        rdchk(13'h1001, 8'h00);
        rdchk(13'h1003, 8'h00);
        rdchk(13'h100d, 8'h00);
    endtask : t_reset

    initial begin
        repeat (5) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        t_skip_set();
        t_skip_clr();
        t_invert();
        t_branch();
        t_call();
        t_reset();
        print_verdict();
    end

    // Whole run needs well under 2000 clocks
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        print_verdict();
    end
endmodule : tb_top

bind bit_test_branch_call_decode slice_asserts u_slice_asserts (
    .clk_sys     (clk_sys),
    .arst_n      (arst_n),
    .prog_addr   (prog_addr),
    .cycle_end   (cycle_end),
    .empty_cycle (empty_cycle)
);

/* File: verilog/bit_test_branch_call_decode.sv */
// Decode and execute of bit-test skips, bit invert, short branches
// and the two-word call, on a 4-clock instruction cycle.
// Assumes program memory answers prog_data for prog_addr in the same
// cycle and that software uses the register port while run is low.
`timescale 1ns/1ns
`include "slice_map.svh"

module bit_test_branch_call_decode #(
    parameter int STACK_DEPTH = 31,
    parameter int DMEM_AW     = 12
) (
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    input  wire logic [15:0] prog_data,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [12:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [20:0] prog_addr,
    output logic      [7:0]  reg_rdata,
    output logic             cycle_end,
    output logic             empty_cycle
);

    // Reset release
    logic rst_meta_q;
    logic rst_n_q;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    function automatic slice_pkg::dec_t decode(input logic [15:0] w);
        slice_pkg::dec_t d;
        d.bit_idx = w[11:9];
        d.acc     = w[8];
        d.file    = w[7:0];
        d.shadow  = w[8];
        d.op      = slice_pkg::OP_NOP;
        if (w[15:12] == `OPC_SKIP_SET)
            d.op = slice_pkg::OP_SKIP_SET;
        else if (w[15:12] == `OPC_SKIP_CLR)
            d.op = slice_pkg::OP_SKIP_CLR;
        else if (w[15:12] == `OPC_INVERT)
            d.op = slice_pkg::OP_INVERT;
        else if (w[15:8] == `OPC_BR_OV)
            d.op = slice_pkg::OP_BR_OV;
        else if (w[15:8] == `OPC_BR_Z)
            d.op = slice_pkg::OP_BR_Z;
        else if (w[15:9] == `OPC_CALL)
            d.op = slice_pkg::OP_CALL;
        return d;
    endfunction : decode

    // Only the call is two words in this slice
    function automatic logic two_word(input logic [15:0] w);
        return w[15:9] == `OPC_CALL;
    endfunction : two_word

    function automatic logic [DMEM_AW-1:0] data_addr(
        input logic       acc,
        input logic [7:0] f,
        input logic [7:0] bank
    );
        logic [3:0] page;
        page = `ACCESS_LO_PAGE;
        if (acc)
            page = bank[3:0];
        else if (f >= `ACCESS_SPLIT)
            page = `ACCESS_HI_PAGE;
        return DMEM_AW'({page, f});
    endfunction : data_addr

    // Pointer zero is the empty stack; a push past the top wraps to zero
    function automatic logic [4:0] ptr_inc(input logic [4:0] p);
        if (p >= 5'(STACK_DEPTH))
            return `PTR_RESET;
        return p + `PTR_STEP;
    endfunction : ptr_inc

    // Only the two flag tests of this slice are decoded here
    function automatic logic branch_taken(
        input slice_pkg::op_t op,
        input logic [7:0]     fl
    );
        return (op == slice_pkg::OP_BR_OV && fl[`ST_OV_BIT])
            || (op == slice_pkg::OP_BR_Z && fl[`ST_Z_BIT]);
    endfunction : branch_taken

    // State
    // Neither memory is reset; software loads the data it needs
    logic [7:0]  dmem [2**DMEM_AW];
    logic [20:0] stack [STACK_DEPTH+1];
    logic [1:0]  phase_q, phase_d;
    logic        run_q, run_d;
    slice_pkg::cyc_state_t st_q, st_d;
    logic [15:0] instr_q, instr_d;
    logic [20:0] pc_q, pc_d;
    logic [7:0]  acc_q, acc_d;
    logic [7:0]  flags_q, flags_d;
    logic [7:0]  bank_q, bank_d;
    logic [7:0]  acc_sh_q, acc_sh_d;
    logic [7:0]  flags_sh_q, flags_sh_d;
    logic [7:0]  bank_sh_q, bank_sh_d;
    logic [4:0]  ptr_q, ptr_d;
    logic [7:0]  rdata_q, rdata_d;
    logic        cend_q, cend_d;
    logic        empty_q, empty_d;
    logic        mem_we;
    logic [DMEM_AW-1:0] mem_wa;
    logic [7:0]  mem_wd;
    logic        stk_we;
    logic [4:0]  stk_wa;
    logic [20:0] stk_wd;

    slice_pkg::reg_req_t req;
    slice_pkg::dec_t     dec;
    logic                q4;
    logic [DMEM_AW-1:0]  fa;
    logic [7:0]          fbyte;
    logic                fbit;
    logic [20:0]         return_stack_top;

    always_comb begin
        req.wr    = reg_wr;
        req.rd    = reg_rd;
        req.addr  = reg_addr;
        req.wdata = reg_wdata;
        dec       = decode(instr_q);
        q4        = run_q && (phase_q == `PHASE_Q4);
        fa        = data_addr(dec.acc, dec.file, bank_q);
        fbyte     = dmem[fa];
        fbit      = fbyte[dec.bit_idx];
        return_stack_top       = stack[ptr_q];
    end

    always_comb begin
        phase_d    = phase_q;
        run_d      = run_q;
        st_d       = st_q;
        instr_d    = instr_q;
        pc_d       = pc_q;
        acc_d      = acc_q;
        flags_d    = flags_q;
        bank_d     = bank_q;
        acc_sh_d   = acc_sh_q;
        flags_sh_d = flags_sh_q;
        bank_sh_d  = bank_sh_q;
        ptr_d      = ptr_q;
        cend_d     = q4;
        empty_d    = 1'b0;
        mem_we     = 1'b0;
        mem_wa     = req.addr[DMEM_AW-1:0];
        mem_wd     = req.wdata;
        stk_we     = 1'b0;
        stk_wa     = ptr_inc(ptr_q);
        stk_wd     = pc_q + `RET_STEP;
        rdata_d    = `BYTE_RESET;

        // Phase holds while stopped, so a restart may resume mid-cycle
        if (run_q)
            phase_d = phase_q + `PHASE_STEP;

        // Software port; core writes below take the memory at Q4
        if (req.wr && !req.addr[`CORE_SEL_BIT]) begin
            mem_we = 1'b1;
        end else if (req.wr) begin
            case (req.addr[3:0])
                `IDX_CTRL:  run_d = req.wdata[`CTRL_RUN_BIT];
                `IDX_ACC:   acc_d = req.wdata;
                `IDX_FLAGS: flags_d = req.wdata;
                `IDX_BANK:  bank_d = req.wdata;
                // PC bit zero is fixed: program words are two bytes
                `IDX_PC_L:  pc_d[7:0] = {req.wdata[7:1], 1'b0};
                `IDX_PC_H:  pc_d[15:8] = req.wdata;
                `IDX_PC_U:  pc_d[20:16] = req.wdata[4:0];
                default:    ;
            endcase
            // A moved PC makes the held fetch stale
            if (req.addr[3:0] == `IDX_PC_L || req.addr[3:0] == `IDX_PC_H
                || req.addr[3:0] == `IDX_PC_U) begin
                st_d = slice_pkg::ST_EMPTY1;
            end
        end

        if (req.rd && !req.addr[`CORE_SEL_BIT]) begin
            rdata_d = dmem[req.addr[DMEM_AW-1:0]];
        end else if (req.rd) begin
            case (req.addr[3:0])
                `IDX_CTRL:     rdata_d = {7'h00, run_q};
                `IDX_ACC:      rdata_d = acc_q;
                `IDX_FLAGS:    rdata_d = flags_q;
                `IDX_BANK:     rdata_d = bank_q;
                `IDX_ACC_SH:   rdata_d = acc_sh_q;
                `IDX_FLAGS_SH: rdata_d = flags_sh_q;
                `IDX_BANK_SH:  rdata_d = bank_sh_q;
                `IDX_PC_L:     rdata_d = pc_q[7:0];
                `IDX_PC_H:     rdata_d = pc_q[15:8];
                `IDX_PC_U:     rdata_d = {3'h0, pc_q[20:16]};
                `IDX_TOS_L:    rdata_d = return_stack_top[7:0];
                `IDX_TOS_H:    rdata_d = return_stack_top[15:8];
                `IDX_TOS_U:    rdata_d = {3'h0, return_stack_top[20:16]};
                `IDX_PTR:      rdata_d = {3'h0, ptr_q};
                default:       rdata_d = `BYTE_RESET;
            endcase
        end

        if (q4) begin
            // Fetch of the next word overlaps every executed cycle
            instr_d = prog_data;
            pc_d    = pc_q + `PC_STEP;
            st_d    = slice_pkg::ST_EXEC;
            case (st_q)
                slice_pkg::ST_EMPTY2: begin
                    empty_d = 1'b1;
                    st_d    = slice_pkg::ST_EMPTY1;
                end
                slice_pkg::ST_EMPTY1: begin
                    empty_d = 1'b1;
                end
                slice_pkg::ST_EXEC: begin
                    case (dec.op)
                        slice_pkg::OP_SKIP_SET,
                        slice_pkg::OP_SKIP_CLR: begin
                            // Bit one for set test, zero for clear test
                            if (fbit == (dec.op == slice_pkg::OP_SKIP_SET))
                            begin
                                st_d = slice_pkg::ST_EMPTY1;
                                if (two_word(prog_data))
                                    st_d = slice_pkg::ST_EMPTY2;
                            end
                        end
                        slice_pkg::OP_INVERT: begin
                            mem_we = 1'b1;
                            mem_wa = fa;
                            mem_wd = fbyte ^ (8'h01 << dec.bit_idx);
                        end
                        slice_pkg::OP_BR_OV,
                        slice_pkg::OP_BR_Z: begin
                            if (branch_taken(dec.op, flags_q)) begin
                                // pc_q already holds the incremented PC
                                pc_d = pc_q + {{12{instr_q[7]}},
                                               instr_q[7:0], 1'b0};
                                st_d = slice_pkg::ST_EMPTY1;
                            end
                        end
                        slice_pkg::OP_CALL: begin
                            stk_we = 1'b1;
                            ptr_d  = ptr_inc(ptr_q);
                            if (dec.shadow) begin
                                acc_sh_d   = acc_q;
                                flags_sh_d = flags_q;
                                bank_sh_d  = bank_q;
                            end
                            // High target comes in with the second word
                            pc_d = {prog_data[11:0], instr_q[7:0],
                                    1'b0};
                            st_d = slice_pkg::ST_EMPTY1;
                        end
                        default: ;
                    endcase
                end
                default: st_d = slice_pkg::ST_EXEC;
            endcase
        end
    end

    // Stack wraps silently on overflow; no fault is raised
    always_ff @(posedge clk_sys) begin
        if (mem_we)
            dmem[mem_wa] <= mem_wd;
        if (stk_we)
            stack[stk_wa] <= stk_wd;
    end

    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            phase_q    <= 2'h0;
            run_q      <= 1'b0;
            st_q       <= slice_pkg::ST_EMPTY1;
            instr_q    <= 16'h0000;
            pc_q       <= `PC_RESET;
            acc_q      <= `BYTE_RESET;
            flags_q    <= `BYTE_RESET;
            bank_q     <= `BYTE_RESET;
            acc_sh_q   <= `BYTE_RESET;
            flags_sh_q <= `BYTE_RESET;
            bank_sh_q  <= `BYTE_RESET;
            ptr_q      <= `PTR_RESET;
            rdata_q    <= `BYTE_RESET;
            cend_q     <= 1'b0;
            empty_q    <= 1'b0;
        end else begin
            phase_q    <= phase_d;
            run_q      <= run_d;
            st_q       <= st_d;
            instr_q    <= instr_d;
            pc_q       <= pc_d;
            acc_q      <= acc_d;
            flags_q    <= flags_d;
            bank_q     <= bank_d;
            acc_sh_q   <= acc_sh_d;
            flags_sh_q <= flags_sh_d;
            bank_sh_q  <= bank_sh_d;
            ptr_q      <= ptr_d;
            rdata_q    <= rdata_d;
            cend_q     <= cend_d;
            empty_q    <= empty_d;
        end
    end

    always_comb begin
        prog_addr   = pc_q;
        reg_rdata   = rdata_q;
        cycle_end   = cend_q;
        empty_cycle = empty_q;
    end

endmodule : bit_test_branch_call_decode

/* File: verilog/slice_map.svh */
// Constants for the bit-test, branch and call slice of the 8-bit core.
// Assumes one 250 MHz clock and a 4-clock instruction cycle.
`ifndef SLICE_MAP_SVH
`define SLICE_MAP_SVH

`define CLK_PERIOD_NS   4
`define PHASE_Q4        2'h3
`define PHASE_STEP      2'h1

`define OPC_SKIP_SET    4'ha
`define OPC_SKIP_CLR    4'hb
`define OPC_INVERT      4'h7
`define OPC_BR_OV       8'he4
`define OPC_BR_Z        8'he0
`define OPC_CALL        7'h76
`define OPC_CALL_HI     4'hf

`define ST_Z_BIT        2
`define ST_OV_BIT       3

`define ACCESS_SPLIT    8'h80
`define ACCESS_LO_PAGE  4'h0
`define ACCESS_HI_PAGE  4'hf

`define PC_STEP         21'h000002
`define PC_RESET        21'h000000
`define RET_STEP        21'h000002
`define BYTE_RESET      8'h00
`define PTR_STEP        5'h01
`define PTR_RESET       5'h00

`define CORE_SEL_BIT    12
`define IDX_CTRL        4'h0
`define IDX_ACC         4'h1
`define IDX_FLAGS       4'h2
`define IDX_BANK        4'h3
`define IDX_ACC_SH      4'h4
`define IDX_FLAGS_SH    4'h5
`define IDX_BANK_SH     4'h6
`define IDX_PC_L        4'h7
`define IDX_PC_H        4'h8
`define IDX_PC_U        4'h9
`define IDX_TOS_L       4'ha
`define IDX_TOS_H       4'hb
`define IDX_TOS_U       4'hc
`define IDX_PTR         4'hd
`define CTRL_RUN_BIT    0

`endif

/* File: verilog/slice_pkg.sv */
// Types shared by the instruction slice.
// Assumes slice_map.svh gives the numeric constants.
package slice_pkg;

    typedef enum logic [2:0] {
        OP_NOP      = 3'h0,
        OP_SKIP_SET = 3'h1,
        OP_SKIP_CLR = 3'h2,
        OP_INVERT   = 3'h3,
        OP_BR_OV    = 3'h4,
        OP_BR_Z     = 3'h5,
        OP_CALL     = 3'h6
    } op_t;

    typedef enum logic [2:0] {
        ST_EXEC   = 3'b001,
        ST_EMPTY1 = 3'b010,
        ST_EMPTY2 = 3'b100
    } cyc_state_t;

    typedef struct packed {
        op_t        op;
        logic [2:0] bit_idx;
        logic       acc;
        logic [7:0] file;
        logic       shadow;
    } dec_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [12:0] addr;
        logic [7:0]  wdata;
    } reg_req_t;

endpackage : slice_pkg
